// ---- ccsmp_core.sv ----
// Core status word, multiply/divide datapath, data pointers and address decode
module ccsmp_core (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Function register port
  input wire logic [7:0] SFR_ADDR_I,
  input wire logic [7:0] SFR_WDATA_I,
  input wire logic SFR_WE_I,
  input wire logic SFR_RE_I,
  output logic [7:0] SFR_RDATA_O,
  output logic SFR_HIT_O,
  output logic SFR_BANK_O,
  // Execution pipeline updates
  input wire logic ACC_WE_I,
  input wire logic [7:0] ACC_DATA_I,
  input wire ccsmp_pkg::ccsmp_flags_type FLAGS_I,
  input wire logic MULT_I,
  input wire logic DIV_I,
  input wire logic PUSH_I,
  input wire logic POP_I,
  input wire logic PTR_WE_I,
  input wire logic [15:0] PTR_DATA_I,
  input wire logic PTR_INC_I,
  // Internal memory decode
  input wire logic MEM_REQ_I,
  input wire logic MEM_INDIRECT_I,
  input wire logic [7:0] MEM_ADDR_I,
  output logic IRAM_SEL_O,
  output logic SFR_SEL_O,
  input wire logic [2:0] REG_IDX_I,
  output logic [7:0] REG_ADDR_O,
  // External memory address
  input wire logic XRAM_REQ_I,
  input wire logic XRAM_USE_PTR_I,
  input wire logic [7:0] XRAM_RI_I,
  output logic XRAM_SEL_O,
  output logic [15:0] XRAM_ADDR_O,
  // Register views
  output logic [7:0] ACC_O,
  output logic [7:0] B_O,
  output logic [7:0] AUX_O,
  output logic [7:0] STATUS_O,
  output logic [7:0] STACK_TOP_O,
  output logic [15:0] PTR_O
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0] acc_r;
  logic [7:0] sec_r;
  logic [7:0] aux_r;
  logic [7:0] status_r;
  logic [7:0] ctrl_r;
  logic [7:0] stack_top_r;
  logic [7:0] pri_low_r;
  logic [7:0] pri_high_r;
  logic [7:0] sec_low_r;
  logic [7:0] sec_high_r;
  logic [5:0] page_r;
  logic [7:0] rdata_r;
  logic hit_r;
  logic parity;
  logic [7:0] status_view;
  logic [15:0] active_ptr;
  logic [15:0] ptr_inc;
  ccsmp_pkg::ccsmp_muldiv_type md;
  logic [23:0] prod;
  logic [15:0] dividend;
  logic [15:0] quot;
  logic [7:0] rem;

  function automatic logic sfr_wr(input logic [7:0] addr, input logic we, input logic [7:0] target);
    sfr_wr = we && (addr == target);
  endfunction

  // ---------------------------------------------------------------
  // Parity and status view
  // ---------------------------------------------------------------
  // Parity is derived, never stored, so it cannot go stale
  assign parity = ^acc_r;
  always_comb begin
    status_view = status_r;
    status_view[ccsmp_pkg::PARITY_POS] = parity;
  end

  // ---------------------------------------------------------------
  // Multiply / divide
  // ---------------------------------------------------------------
  always_comb begin
    prod = 24'h000000;
    dividend = 16'h0000;
    quot = 16'h0000;
    rem = 8'h00;
    md = '0;
    if (MULT_I) begin
      if (ctrl_r[ccsmp_pkg::PROD_WIDTH_POS]) begin
        prod = 24'({aux_r, acc_r}) * 24'(sec_r);
        md.accum = prod[7:0];
        md.secondary = prod[15:8];
        md.aux = prod[23:16];
        md.aux_we = 1'b1;
        md.overflow = |prod[23:16];
      end else begin
        prod = 24'(acc_r) * 24'(sec_r);
        md.accum = prod[7:0];
        md.secondary = prod[15:8];
        md.aux = aux_r;
        md.overflow = |prod[15:8];
      end
    end else begin
      // Division by zero leaves operands as they are and flags overflow
      dividend = ctrl_r[ccsmp_pkg::QUOT_WIDTH_POS] ? {aux_r, acc_r} : {8'h00, acc_r};
      if (sec_r == 8'h00) begin
        md.accum = acc_r;
        md.secondary = sec_r;
        md.aux = aux_r;
        md.overflow = 1'b1;
      end else begin
        quot = dividend / {8'h00, sec_r};
        rem = 8'((dividend % {8'h00, sec_r}));
        md.accum = quot[7:0];
        md.secondary = rem;
        md.aux = quot[15:8];
        md.aux_we = ctrl_r[ccsmp_pkg::QUOT_WIDTH_POS];
      end
    end
  end

  // ---------------------------------------------------------------
  // Accumulator, secondary and auxiliary registers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      acc_r <= ccsmp_pkg::RESET_BYTE;
      sec_r <= ccsmp_pkg::RESET_BYTE;
      aux_r <= ccsmp_pkg::RESET_BYTE;
    end else if (MULT_I || DIV_I) begin
      acc_r <= md.accum;
      sec_r <= md.secondary;
      if (md.aux_we) begin
        aux_r <= md.aux;
      end
    end else begin
      if (ACC_WE_I) begin
        acc_r <= ACC_DATA_I;
      end else if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_ACCUM)) begin
        acc_r <= SFR_WDATA_I;
      end
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_SECONDARY)) begin
        sec_r <= SFR_WDATA_I;
      end
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_AUX_RESULT)) begin
        aux_r <= SFR_WDATA_I;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status word
  // ---------------------------------------------------------------
  // Hardware flag updates win over a software write in the same cycle
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      status_r <= ccsmp_pkg::RESET_STATUS;
    end else begin
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_STATUS_WORD)) begin
        status_r[7:1] <= SFR_WDATA_I[7:1];
      end
      if (MULT_I || DIV_I) begin
        status_r[ccsmp_pkg::CARRY_POS] <= 1'b0;
        status_r[ccsmp_pkg::OVERFLOW_POS] <= md.overflow;
      end else begin
        if (FLAGS_I.carry_we) begin
          status_r[ccsmp_pkg::CARRY_POS] <= FLAGS_I.carry;
        end
        if (FLAGS_I.half_carry_we) begin
          status_r[ccsmp_pkg::HALF_CARRY_POS] <= FLAGS_I.half_carry;
        end
        if (FLAGS_I.overflow_we) begin
          status_r[ccsmp_pkg::OVERFLOW_POS] <= FLAGS_I.overflow;
        end
      end
      status_r[ccsmp_pkg::PARITY_POS] <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Extension control and page register
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      ctrl_r <= ccsmp_pkg::RESET_INSN_EXT;
    end else if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_INSN_EXT_CTRL)) begin
      ctrl_r <= SFR_WDATA_I & ccsmp_pkg::INSN_EXT_MASK;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      page_r <= ccsmp_pkg::RESET_PAGE;
    end else if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_EXT_PAGE)) begin
      page_r <= SFR_WDATA_I[5:0];
    end
  end

  // ---------------------------------------------------------------
  // Stack top
  // ---------------------------------------------------------------
  // Push takes priority over pop if the pipeline asserts both
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      stack_top_r <= ccsmp_pkg::RESET_STACK_TOP;
    end else if (PUSH_I) begin
      stack_top_r <= stack_top_r + 8'h01;
    end else if (POP_I) begin
      stack_top_r <= stack_top_r - 8'h01;
    end else if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_STACK_TOP)) begin
      stack_top_r <= SFR_WDATA_I;
    end
  end

  // ---------------------------------------------------------------
  // Data pointers
  // ---------------------------------------------------------------
  assign active_ptr = ctrl_r[ccsmp_pkg::PTR_SEL_POS] ? {sec_high_r, sec_low_r} : {pri_high_r, pri_low_r};
  assign ptr_inc = active_ptr + 16'h0001;

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      pri_low_r <= ccsmp_pkg::RESET_BYTE;
      pri_high_r <= ccsmp_pkg::RESET_BYTE;
    end else if (!ctrl_r[ccsmp_pkg::PTR_SEL_POS] && (PTR_WE_I || PTR_INC_I)) begin
      {pri_high_r, pri_low_r} <= PTR_WE_I ? PTR_DATA_I : ptr_inc;
    end else begin
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_PRI_LOW)) begin
        pri_low_r <= SFR_WDATA_I;
      end
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_PRI_HIGH)) begin
        pri_high_r <= SFR_WDATA_I;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      sec_low_r <= ccsmp_pkg::RESET_BYTE;
      sec_high_r <= ccsmp_pkg::RESET_BYTE;
    end else if (ctrl_r[ccsmp_pkg::PTR_SEL_POS] && (PTR_WE_I || PTR_INC_I)) begin
      {sec_high_r, sec_low_r} <= PTR_WE_I ? PTR_DATA_I : ptr_inc;
    end else begin
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_SEC_LOW)) begin
        sec_low_r <= SFR_WDATA_I;
      end
      if (sfr_wr(SFR_ADDR_I, SFR_WE_I, ccsmp_pkg::ADDR_SEC_HIGH)) begin
        sec_high_r <= SFR_WDATA_I;
      end
    end
  end

  // ---------------------------------------------------------------
  // Function register read port
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RESETN_I) begin
      rdata_r <= ccsmp_pkg::RESET_BYTE;
      hit_r <= 1'b0;
    end else if (SFR_RE_I) begin
      hit_r <= 1'b1;
      case (SFR_ADDR_I)
        ccsmp_pkg::ADDR_STACK_TOP: rdata_r <= stack_top_r;
        ccsmp_pkg::ADDR_PRI_LOW: rdata_r <= pri_low_r;
        ccsmp_pkg::ADDR_PRI_HIGH: rdata_r <= pri_high_r;
        ccsmp_pkg::ADDR_SEC_LOW: rdata_r <= sec_low_r;
        ccsmp_pkg::ADDR_SEC_HIGH: rdata_r <= sec_high_r;
        ccsmp_pkg::ADDR_INSN_EXT_CTRL: rdata_r <= ctrl_r;
        ccsmp_pkg::ADDR_STATUS_WORD: rdata_r <= status_view;
        ccsmp_pkg::ADDR_ACCUM: rdata_r <= acc_r;
        ccsmp_pkg::ADDR_SECONDARY: rdata_r <= sec_r;
        ccsmp_pkg::ADDR_AUX_RESULT: rdata_r <= aux_r;
        ccsmp_pkg::ADDR_EXT_PAGE: rdata_r <= {2'b00, page_r};
        default: begin
          rdata_r <= 8'h00;
          hit_r <= 1'b0;
        end
      endcase
    end else begin
      rdata_r <= 8'h00;
      hit_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  // Upper RAM and function registers share addresses; mode decides
  assign IRAM_SEL_O = MEM_REQ_I && (MEM_INDIRECT_I || (MEM_ADDR_I <= ccsmp_pkg::LOWER_RAM_TOP));
  assign SFR_SEL_O = MEM_REQ_I && !MEM_INDIRECT_I && (MEM_ADDR_I > ccsmp_pkg::LOWER_RAM_TOP);
  assign REG_ADDR_O = {3'b000, status_r[ccsmp_pkg::BANK_HI_POS:ccsmp_pkg::BANK_LO_POS], REG_IDX_I};
  assign XRAM_SEL_O = XRAM_REQ_I;
  assign XRAM_ADDR_O = XRAM_USE_PTR_I ? active_ptr : {2'b00, page_r, XRAM_RI_I};

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign SFR_RDATA_O = rdata_r;
  assign SFR_HIT_O = hit_r;
  assign SFR_BANK_O = ctrl_r[ccsmp_pkg::SFR_BANK_POS];
  assign ACC_O = acc_r;
  assign B_O = sec_r;
  assign AUX_O = aux_r;
  assign STATUS_O = status_view;
  assign STACK_TOP_O = stack_top_r;
  assign PTR_O = active_ptr;

endmodule // ccsmp_core

// ---- ccsmp_pkg.sv ----
// Shared constants and types for the core status, multiply/divide and pointer block
package ccsmp_pkg;

  // ---------------------------------------------------------------
  // Special function register addresses (present in both banks)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_STACK_TOP = 8'h81;
  localparam logic [7:0] ADDR_PRI_LOW = 8'h82;
  localparam logic [7:0] ADDR_PRI_HIGH = 8'h83;
  localparam logic [7:0] ADDR_SEC_LOW = 8'h84;
  localparam logic [7:0] ADDR_SEC_HIGH = 8'h85;
  localparam logic [7:0] ADDR_INSN_EXT_CTRL = 8'h86;
  localparam logic [7:0] ADDR_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_ACCUM = 8'hE0;
  localparam logic [7:0] ADDR_SECONDARY = 8'hF0;
  localparam logic [7:0] ADDR_AUX_RESULT = 8'hF1;
  localparam logic [7:0] ADDR_EXT_PAGE = 8'hF7;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CARRY_POS = 7;
  localparam int HALF_CARRY_POS = 6;
  localparam int USER_HIGH_POS = 5;
  localparam int BANK_HI_POS = 4;
  localparam int BANK_LO_POS = 3;
  localparam int OVERFLOW_POS = 2;
  localparam int USER_LOW_POS = 1;
  localparam int PARITY_POS = 0;
  localparam int SFR_BANK_POS = 6;
  localparam int QUOT_WIDTH_POS = 3;
  localparam int PROD_WIDTH_POS = 2;
  localparam int PTR_SEL_POS = 0;

  // ---------------------------------------------------------------
  // Writable masks, lower RAM boundary and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] INSN_EXT_MASK = 8'h4D;
  localparam logic [7:0] EXT_PAGE_MASK = 8'h3F;
  localparam logic [7:0] LOWER_RAM_TOP = 8'h7F;
  localparam logic [7:0] RESET_STATUS = 8'h00;
  localparam logic [7:0] RESET_INSN_EXT = 8'h00;
  localparam logic [7:0] RESET_STACK_TOP = 8'h07;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [5:0] RESET_PAGE = 6'h00;

  // Flag update from the execution pipeline
  typedef struct packed {
    logic carry_we;
    logic carry;
    logic half_carry_we;
    logic half_carry;
    logic overflow_we;
    logic overflow;
  } ccsmp_flags_type;

  // Multiply/divide outcome
  typedef struct packed {
    logic [7:0] accum;
    logic [7:0] secondary;
    logic [7:0] aux;
    logic aux_we;
    logic overflow;
  } ccsmp_muldiv_type;

endpackage

// ---- ccsmp_assertions.sv ----
// Port-level checks of decode, parity and stack behaviour of the core block
module ccsmp_assertions (
  input wire logic CLK_I,
  input wire logic RESETN_I,
  input wire logic PUSH_I,
  input wire logic POP_I,
  input wire logic MEM_REQ_I,
  input wire logic MEM_INDIRECT_I,
  input wire logic [7:0] MEM_ADDR_I,
  input wire logic IRAM_SEL_O,
  input wire logic SFR_SEL_O,
  input wire logic [2:0] REG_IDX_I,
  input wire logic [7:0] REG_ADDR_O,
  input wire logic XRAM_REQ_I,
  input wire logic XRAM_USE_PTR_I,
  input wire logic [7:0] XRAM_RI_I,
  input wire logic [15:0] XRAM_ADDR_O,
  input wire logic [7:0] ACC_O,
  input wire logic [7:0] STATUS_O,
  input wire logic [7:0] STACK_TOP_O,
  input wire logic [15:0] PTR_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RESETN_I);
  a_parity_follows_acc: assert property (STATUS_O[0] == ^ACC_O)
    else $error("parity bit wrong");
  a_bank_reg_addr: assert property (REG_ADDR_O == {3'h0, STATUS_O[4:3], REG_IDX_I})
    else $error("bank address wrong");
  a_iram_sel_decode: assert property (IRAM_SEL_O == (MEM_REQ_I && (MEM_INDIRECT_I || !MEM_ADDR_I[7])))
    else $error("ram select wrong");
  a_sfr_sel_decode: assert property (SFR_SEL_O == (MEM_REQ_I && !MEM_INDIRECT_I && MEM_ADDR_I[7]))
    else $error("register select wrong");
  a_xram_ptr_addr: assert property (XRAM_REQ_I && XRAM_USE_PTR_I |-> XRAM_ADDR_O == PTR_O)
    else $error("pointer address wrong");
  a_xram_page_addr: assert property (XRAM_REQ_I && !XRAM_USE_PTR_I |-> XRAM_ADDR_O[7:0] == XRAM_RI_I)
    else $error("paged address wrong");
  a_push_pre_inc: assert property (PUSH_I |=> STACK_TOP_O == $past(STACK_TOP_O) + 8'h01)
    else $error("push step wrong");
  a_pop_post_dec: assert property (POP_I && !PUSH_I |=> STACK_TOP_O == $past(STACK_TOP_O) - 8'h01)
    else $error("pop step wrong");
endmodule // ccsmp_assertions

// ---- ccsmp_pipe_model.sv ----
// Execution pipeline stand-in issuing one-cycle update strobes
module ccsmp_pipe_model (
  input wire logic clk_i,
  output logic [6:0] strobe_o,
  output logic [15:0] data_o,
  output ccsmp_pkg::ccsmp_flags_type flags_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    strobe_o = 7'h00;
    data_o = 16'h0000;
    flags_o = 6'h00;
  end
  // Quiet cycle after each strobe so calls never collide; stale data inverted
  task automatic issue(input logic [6:0] kind, input logic [15:0] data);
    @(negedge clk_i);
    strobe_o = kind;
    data_o = data;
    flags_o = data[5:0];
    @(negedge clk_i);
    strobe_o = 7'h00;
    data_o = ~data;
    flags_o = 6'h00;
  endtask
endmodule // ccsmp_pipe_model

// ---- ccsmp_core_test.sv ----
// Self-checking bench for the core status, multiply/divide and pointer block
module ccsmp_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] ctrl, aux, acc, b;
    logic [6:0] op;
    logic [7:0] e_acc, e_b, e_aux;
    logic e_ov;
  } ccsmp_row_type;
  ccsmp_row_type rows [6] = '{
    {8'h00, 8'h55, 8'h0C, 8'h0B, 7'h20, 8'h84, 8'h00, 8'h55, 1'h0},
    {8'h00, 8'h55, 8'hFF, 8'hFF, 7'h20, 8'h01, 8'hFE, 8'h55, 1'h1},
    {8'h04, 8'h12, 8'h34, 8'h10, 7'h20, 8'h40, 8'h23, 8'h01, 1'h1},
    {8'h00, 8'h12, 8'h64, 8'h07, 7'h10, 8'h0E, 8'h02, 8'h12, 1'h0},
    {8'h08, 8'h12, 8'h34, 8'h10, 7'h10, 8'h23, 8'h04, 8'h01, 1'h0},
    {8'h00, 8'h12, 8'h34, 8'h00, 7'h10, 8'h34, 8'h00, 8'h12, 1'h1}};
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [7:0] s_addr = 8'h00, s_wdata = 8'h00, m_addr = 8'h00, ri = 8'h00;
  logic s_we = 1'h0, s_re = 1'h0, m_req = 1'h0, m_ind = 1'h0, x_req = 1'h0, x_dp = 1'h0;
  logic [2:0] idx = 3'h0;
  logic [7:0] rdata, reg_addr, acc, b, aux, status, stack_top;
  logic hit, bank, iram, sfr, xsel;
  logic [15:0] xaddr, ptr, pdata;
  logic [6:0] stb;
  logic [8:0] got;
  ccsmp_pkg::ccsmp_flags_type flags;
  ccsmp_row_type r;
  int num_errors = 0;
  int n_checks = 0;
  initial begin
    forever #2.5 clk = ~clk;
  end
  ccsmp_pipe_model ccsmp_pipe_model_i (.clk_i(clk), .strobe_o(stb), .data_o(pdata), .flags_o(flags));
  ccsmp_core ccsmp_core_i (.CLK_I(clk), .RESETN_I(rst_n), .SFR_ADDR_I(s_addr), .SFR_WDATA_I(s_wdata),
    .SFR_WE_I(s_we), .SFR_RE_I(s_re), .SFR_RDATA_O(rdata), .SFR_HIT_O(hit), .SFR_BANK_O(bank),
    .ACC_WE_I(stb[6]), .ACC_DATA_I(pdata[7:0]), .FLAGS_I(flags), .MULT_I(stb[5]), .DIV_I(stb[4]),
    .PUSH_I(stb[3]), .POP_I(stb[2]), .PTR_WE_I(stb[1]), .PTR_DATA_I(pdata), .PTR_INC_I(stb[0]),
    .MEM_REQ_I(m_req), .MEM_INDIRECT_I(m_ind), .MEM_ADDR_I(m_addr), .IRAM_SEL_O(iram), .SFR_SEL_O(sfr),
    .REG_IDX_I(idx), .REG_ADDR_O(reg_addr), .XRAM_REQ_I(x_req), .XRAM_USE_PTR_I(x_dp), .XRAM_RI_I(ri),
    .XRAM_SEL_O(xsel), .XRAM_ADDR_O(xaddr), .ACC_O(acc), .B_O(b), .AUX_O(aux), .STATUS_O(status),
    .STACK_TOP_O(stack_top), .PTR_O(ptr));
  // Wide enough for the longest packed comparison, so nothing is cut
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    s_we = 1'h1;
    s_addr = a;
    s_wdata = d;
    @(negedge clk);
    s_we = 1'h0;
    s_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk);
    s_re = 1'h1;
    s_addr = a;
    @(negedge clk);
    s_re = 1'h0;
    got = {hit, rdata};
  endtask
  task automatic finish_test();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'h1;
    for (int i = 0; i < 6; i++) begin
      r = rows[i];
      wr(8'h86, r.ctrl);
      wr(8'hF1, r.aux);
      wr(8'hF0, r.b);
      ccsmp_pipe_model_i.issue(7'h40, {8'h00, r.acc});
      ccsmp_pipe_model_i.issue(r.op, 16'h0000);
      chk({acc, b, aux}, {r.e_acc, r.e_b, r.e_aux});
      chk({status[7], status[2]}, {1'h0, r.e_ov});
    end
    ccsmp_pipe_model_i.issue(7'h40, 16'h0000);
    wr(8'hD0, 8'hFF);
    rd(8'hD0);
    chk(got, 9'h1FE);
    ccsmp_pipe_model_i.issue(7'h40, 16'h0007);
    chk(status, 8'hFF);
    ccsmp_pipe_model_i.issue(7'h00, 16'h002A);
    chk(status, 8'h3B);
    ccsmp_pipe_model_i.issue(7'h00, 16'h003F);
    chk(status, 8'hFF);
    idx = 3'h5;
    for (int j = 0; j < 4; j++) begin
      wr(8'hD0, {3'h0, 2'(j), 3'h0});
      chk(reg_addr, {3'h0, 2'(j), 3'h5});
    end
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      m_req = 1'h1;
      m_ind = k[0];
      m_addr = k[1] ? 8'h80 : 8'h7F;
      #1;
      chk({iram, sfr}, {k[0] | !k[1], !k[0] & k[1]});
    end
    wr(8'h86, 8'h00);
    ccsmp_pipe_model_i.issue(7'h02, 16'h1234);
    wr(8'h84, 8'hAB);
    wr(8'h85, 8'hCD);
    chk(ptr, 16'h1234);
    wr(8'h86, 8'h01);
    chk(ptr, 16'hCDAB);
    ccsmp_pipe_model_i.issue(7'h01, 16'h0000);
    chk(ptr, 16'hCDAC);
    rd(8'h82);
    chk(got, 9'h134);
    rd(8'h83);
    chk(got, 9'h112);
    x_req = 1'h1;
    x_dp = 1'h1;
    wr(8'hF7, 8'hFF);
    chk({xsel, xaddr}, 17'h1CDAC);
    x_dp = 1'h0;
    ri = 8'h5A;
    #1;
    chk(xaddr, 16'h3F5A);
    wr(8'h86, 8'hFF);
    rd(8'h86);
    chk({got, bank}, 10'h29B);
    rd(8'h87);
    chk(got, 9'h000);
    ccsmp_pipe_model_i.issue(7'h08, 16'h0000);
    chk(stack_top, 8'h08);
    ccsmp_pipe_model_i.issue(7'h04, 16'h0000);
    chk(stack_top, 8'h07);
    wr(8'h81, 8'h40);
    @(negedge clk);
    rst_n = 1'h0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    chk({stack_top, status, ptr}, 32'h07000000);
    rd(8'h86);
    chk(got, 9'h100);
    wr(8'hF1, 8'h12);
    wr(8'hF0, 8'h0B);
    ccsmp_pipe_model_i.issue(7'h40, 16'h000C);
    ccsmp_pipe_model_i.issue(7'h20, 16'h0000);
    chk({acc, b, aux}, 24'h840012);
    finish_test();
  end
endmodule // ccsmp_core_test
bind ccsmp_core ccsmp_assertions ccsmp_assertions_i (.*);
